// ### rtl/psc_pkg.sv
// Constants and types shared by the power-state controller files
package psc_pkg;

  // ---------------------------------------------------------------
  // Clock rate and timing
  // ---------------------------------------------------------------
  localparam int CORE_CLK_KHZ = 125000;
  // Power-up reset pulse width, least time
  localparam int POR_PULSE_NS = 1000;
  localparam int POR_CYCLES = (POR_PULSE_NS * CORE_CLK_KHZ + 999999) / 1000000;
  // Powerdown pin low time that resets the whole chip
  localparam int PD_RESET_MS = 5;
  localparam int PD_RESET_CYCLES = PD_RESET_MS * CORE_CLK_KHZ;
  // Oscillator and PLL settle time after sleep
  localparam int SETTLE_MS = 20;
  localparam int SETTLE_CYCLES = SETTLE_MS * CORE_CLK_KHZ;
  localparam int CNT_W = 22;
  localparam int LOW_W = 20;

  // ---------------------------------------------------------------
  // Serial frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int BITCNT_W = 5;
  localparam logic [1:0] PFX_READ = 2'h0;
  localparam logic [1:0] PFX_HOSTCMD = 2'h1;
  localparam logic [21:0] WAKE_ADDR = 22'h000000;
  localparam logic [5:0] CMD_ACTIVE = 6'h00;
  localparam logic [5:0] CMD_STANDBY = 6'h01;
  localparam logic [5:0] CMD_SLEEP = 6'h02;
  localparam logic [5:0] CMD_PWRDOWN = 6'h03;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  // Synchroniser order: powerdown pin, regulator ok, select, toggle
  localparam int NSYNC = 4;
  // Pin, regulator and select reset to their idle high levels, so no false edge follows reset
  localparam logic [NSYNC-1:0] SYNC_RST = 4'h7;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_WAKE = 3'h1,
    OP_ACTIVE = 3'h2,
    OP_STANDBY = 3'h3,
    OP_SLEEP = 3'h4,
    OP_PDOWN = 3'h5
  } psc_op_t;

  // Gray codes along powerup, standby, active, sleep, wake
  typedef enum logic [2:0] {
    ST_PWRUP = 3'h0,
    ST_STANDBY = 3'h1,
    ST_ACTIVE = 3'h3,
    ST_SLEEP = 3'h2,
    ST_WAKE = 3'h6,
    ST_PDOWN = 3'h7
  } psc_state_t;

endpackage : psc_pkg

// ### rtl/psc_evt_if.sv
// Event carrier from the serial-clock side to the core-clock side
`timescale 1ns/1ps
interface psc_evt_if;
  import psc_pkg::*;
  // Toggles once per decoded frame; op is stable between toggles
  logic tgl;
  psc_op_t op;
  modport tx (output tgl, output op);
  modport rx (input tgl, input op);
endinterface : psc_evt_if

// ### rtl/psc_link_rx.sv
// Serial host frame decoder, clocked by the host serial clock
`timescale 1ns/1ps
module psc_link_rx
  import psc_pkg::*;
(
  // Clocks and reset
  input wire logic host_sck,
  input wire logic reset_n,
  // Host serial pins
  input wire logic host_select_line_n,
  input wire logic host_mosi,
  // Decoded events
  psc_evt_if.tx evt
);

  logic [FRAME_BITS-2:0] sh_r, sh_nxt;
  logic [BITCNT_W-1:0] cnt_r, cnt_nxt;
  logic tgl_r, tgl_nxt;
  psc_op_t op_r, op_nxt;
  logic [FRAME_BITS-1:0] word;

  // ---------------------------------------------------------------
  // Frame decode
  // ---------------------------------------------------------------
  // Bits shift in MSB first; the third byte completes a frame
  always_comb begin
    word = {sh_r, host_mosi};
    sh_nxt = word[FRAME_BITS-2:0];
    cnt_nxt = cnt_r;
    tgl_nxt = tgl_r;
    op_nxt = op_r;
    if (cnt_r != BITCNT_W'(FRAME_BITS)) begin
      cnt_nxt = cnt_r + 1'b1;
    end
    if (cnt_r == BITCNT_W'(FRAME_BITS - 1)) begin
      if (word[23:22] == PFX_READ && word[21:0] == WAKE_ADDR) begin
        op_nxt = OP_WAKE;
        tgl_nxt = ~tgl_r;
      end else if (word[23:22] == PFX_HOSTCMD) begin
        tgl_nxt = ~tgl_r;
        case (word[21:16])
          CMD_ACTIVE: op_nxt = OP_ACTIVE;
          CMD_STANDBY: op_nxt = OP_STANDBY;
          CMD_SLEEP: op_nxt = OP_SLEEP;
          CMD_PWRDOWN: op_nxt = OP_PDOWN;
          default: op_nxt = OP_NONE;
        endcase
      end
    end
  end

  // Bit position restarts whenever the select line is released
  always_ff @(posedge host_sck or posedge host_select_line_n) begin
    if (host_select_line_n) begin
      sh_r <= '0;
      cnt_r <= '0;
    end else begin
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Event word survives the frame; only chip reset clears it
  always_ff @(posedge host_sck or negedge reset_n) begin
    if (!reset_n) begin
      tgl_r <= 1'b0;
      op_r <= OP_NONE;
    end else begin
      tgl_r <= tgl_nxt;
      op_r <= op_nxt;
    end
  end

  assign evt.tgl = tgl_r;
  assign evt.op = op_r;

endmodule : psc_link_rx

// ### rtl/psc_power_ctrl.sv
// Power-state controller: state machine, clock gating and resets
//
// Contract
// - Regulator rise emits core power-on reset pulse
// - Pin low 5 ms then high resets chip
// - After power-up, stay in standby
// - Read of address zero wakes standby
// - Engines run only in active state
// - Host command enters standby, sleep or powerdown
// - Powerdown pin low forces powerdown always
// - Active: oscillator, PLL, system clock on
// - Standby: oscillator, PLL on, clock gated
// - Sleep: oscillator, PLL, clock off, retained
// - Powerdown: all off, serial alive, reset
// - Command powerdown exits by active, pin high
// - Leaving powerdown resets, keeps pin settings
// - Standby wake accepts accesses at once
// - Active to standby/sleep holds all pins
// - Reset: data out floats while deselected
`timescale 1ns/1ps
module psc_power_ctrl
  import psc_pkg::*;
#(
  parameter int PD_RESET_CYC = psc_pkg::PD_RESET_CYCLES,
  parameter int SETTLE_CYC = psc_pkg::SETTLE_CYCLES
) (
  // Core clock and chip reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Host serial link
  input wire logic host_sck,
  input wire logic host_select_line_n,
  input wire logic host_mosi,
  // Asynchronous pins
  input wire logic powerdown_reset_pin_n,
  input wire logic regulator_ok,
  // Clock and power controls
  output logic osc_en,
  output logic pll_en,
  output logic sysclk_en,
  output logic engine_en,
  output logic core_pwr_en,
  // Resets to the core
  output logic core_rst_n,
  output logic chip_rst_n,
  // Pin control
  output logic pin_hold,
  output logic host_miso_oe,
  // Status
  output psc_pkg::psc_state_t power_state,
  output logic pd_by_pin
);

  // ---------------------------------------------------------------
  // Serial decoder in the host clock domain
  // ---------------------------------------------------------------
  psc_evt_if evt ();

  psc_link_rx u_rx (
    .host_sck(host_sck),
    .reset_n(reset_n),
    .host_select_line_n(host_select_line_n),
    .host_mosi(host_mosi),
    .evt(evt)
  );

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [NSYNC-1:0] sync_in;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;

  assign sync_in = {evt.tgl, host_select_line_n,
                    regulator_ok, powerdown_reset_pin_n};

  // Two flops per asynchronous level, third for edge detection
  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_r[i] <= SYNC_RST[i];
          s2_r[i] <= SYNC_RST[i];
          s3_r[i] <= SYNC_RST[i];
        end else begin
          s1_r[i] <= sync_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
        end
      end
    end
  endgenerate

  logic pin_high;
  logic reg_rise;
  logic sel_n;
  logic ev;
  psc_op_t op;

  assign pin_high = s2_r[0];
  assign reg_rise = s2_r[1] & ~s3_r[1];
  assign sel_n = s2_r[2];
  // Op word moved on the same serial clock edge as its toggle and has settled by the time ev is seen
  assign ev = s2_r[3] ^ s3_r[3];
  assign op = ev ? evt.op : OP_NONE;

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  psc_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [LOW_W-1:0] low_r, low_nxt;
  logic long_low_r, long_low_nxt;
  logic go_act_r, go_act_nxt;
  logic full_r, full_nxt;
  logic by_pin_r, by_pin_nxt;
  logic hold_r, hold_nxt;

  // Output flops
  logic osc_r, osc_nxt;
  logic sysclk_r, sysclk_nxt;
  logic pwr_r, pwr_nxt;
  logic crst_r, crst_nxt;
  logic chrst_r, chrst_nxt;
  logic oe_r, oe_nxt;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Pin and regulator events outrank every host command
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    low_nxt = low_r;
    long_low_nxt = long_low_r;
    go_act_nxt = go_act_r;
    full_nxt = full_r;
    by_pin_nxt = by_pin_r;
    hold_nxt = hold_r;

    // Measure how long the powerdown pin stays low
    if (pin_high) begin
      low_nxt = '0;
    end else if (low_r != LOW_W'(PD_RESET_CYC)) begin
      low_nxt = low_r + 1'b1;
    end
    if (!pin_high && low_nxt == LOW_W'(PD_RESET_CYC)) begin
      long_low_nxt = 1'b1;
    end

    if (reg_rise) begin
      // Fresh supply: full power-up reset
      state_nxt = ST_PWRUP;
      cnt_nxt = '0;
      full_nxt = 1'b1;
      go_act_nxt = 1'b0;
      hold_nxt = 1'b0;
    end else if (!pin_high) begin
      if (state_r != ST_PDOWN) begin
        by_pin_nxt = 1'b1;
      end
      state_nxt = ST_PDOWN;
      hold_nxt = 1'b0;
    end else if (long_low_r) begin
      // Pin released after a long low: reset the whole chip
      long_low_nxt = 1'b0;
      state_nxt = ST_PWRUP;
      cnt_nxt = '0;
      full_nxt = 1'b1;
      go_act_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_PWRUP: begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == CNT_W'(POR_CYCLES - 1)) begin
            cnt_nxt = '0;
            full_nxt = 1'b0;
            // Idle in standby unless an active command in powerdown started this
            state_nxt = go_act_r ? ST_ACTIVE : ST_STANDBY;
            go_act_nxt = 1'b0;
          end
        end
        ST_STANDBY: begin
          if (op == OP_WAKE || op == OP_ACTIVE) begin
            // Clocks never stopped, so no settle wait
            state_nxt = ST_ACTIVE;
            hold_nxt = 1'b0;
          end else if (op == OP_SLEEP) begin
            state_nxt = ST_SLEEP;
          end else if (op == OP_PDOWN) begin
            state_nxt = ST_PDOWN;
            by_pin_nxt = 1'b0;
            hold_nxt = 1'b0;
          end
        end
        ST_ACTIVE: begin
          if (op == OP_STANDBY) begin
            state_nxt = ST_STANDBY;
            hold_nxt = 1'b1;
          end else if (op == OP_SLEEP) begin
            state_nxt = ST_SLEEP;
            hold_nxt = 1'b1;
          end else if (op == OP_PDOWN) begin
            state_nxt = ST_PDOWN;
            by_pin_nxt = 1'b0;
          end
        end
        ST_SLEEP: begin
          if (op == OP_WAKE || op == OP_ACTIVE) begin
            state_nxt = ST_WAKE;
            cnt_nxt = '0;
          end else if (op == OP_PDOWN) begin
            state_nxt = ST_PDOWN;
            by_pin_nxt = 1'b0;
            hold_nxt = 1'b0;
          end
        end
        ST_WAKE: begin
          // Engines wait for the oscillator and PLL to settle
          cnt_nxt = cnt_r + 1'b1;
          if (op == OP_PDOWN) begin
            state_nxt = ST_PDOWN;
            by_pin_nxt = 1'b0;
            hold_nxt = 1'b0;
          end else if (cnt_r == CNT_W'(SETTLE_CYC - 1)) begin
            state_nxt = ST_ACTIVE;
            cnt_nxt = '0;
            hold_nxt = 1'b0;
          end
        end
        ST_PDOWN: begin
          // Of host commands only active leaves, and only with pin high
          if (op == OP_ACTIVE) begin
            state_nxt = ST_PWRUP;
            cnt_nxt = '0;
            full_nxt = 1'b0;
            go_act_nxt = 1'b1;
          end
        end
        default: begin
          state_nxt = ST_PWRUP;
          cnt_nxt = '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Output decode from the next state
  // ---------------------------------------------------------------
  // Registered from next values so each output is a flop
  always_comb begin
    osc_nxt = state_nxt != ST_SLEEP && state_nxt != ST_PDOWN;
    sysclk_nxt = state_nxt == ST_ACTIVE;
    pwr_nxt = state_nxt != ST_PDOWN;
    // Core registers clear in power-up and powerdown
    crst_nxt = state_nxt != ST_PWRUP && state_nxt != ST_PDOWN;
    // Pin-state settings clear only on a full power-up
    chrst_nxt = !(state_nxt == ST_PWRUP && full_nxt);
    // Data out floats whenever the host is not selecting us
    oe_nxt = !sel_n;
  end

  // ---------------------------------------------------------------
  // State flops
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_PWRUP;
      cnt_r <= '0;
      low_r <= '0;
      long_low_r <= 1'b0;
      go_act_r <= 1'b0;
      full_r <= 1'b1;
      by_pin_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      low_r <= low_nxt;
      long_low_r <= long_low_nxt;
      go_act_r <= go_act_nxt;
      full_r <= full_nxt;
      by_pin_r <= by_pin_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Output flops
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_r <= 1'b1;
      sysclk_r <= 1'b0;
      pwr_r <= 1'b1;
      crst_r <= 1'b0;
      chrst_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      osc_r <= osc_nxt;
      sysclk_r <= sysclk_nxt;
      pwr_r <= pwr_nxt;
      crst_r <= crst_nxt;
      chrst_r <= chrst_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Port drive
  // ---------------------------------------------------------------
  // PLL shares the oscillator enable; both stop together
  assign osc_en = osc_r;
  assign pll_en = osc_r;
  assign sysclk_en = sysclk_r;
  assign engine_en = sysclk_r;
  assign core_pwr_en = pwr_r;
  assign core_rst_n = crst_r;
  assign chip_rst_n = chrst_r;
  assign pin_hold = hold_r;
  assign host_miso_oe = oe_r;
  assign power_state = state_r;
  assign pd_by_pin = by_pin_r;

endmodule : psc_power_ctrl

// ### tb/psc_power_chk.sv
// Port assertions for the power-state controller
`timescale 1ns/1ps
module psc_power_chk
  import psc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Host link and pins
  input wire logic host_sck,
  input wire logic host_select_line_n,
  input wire logic host_mosi,
  input wire logic powerdown_reset_pin_n,
  input wire logic regulator_ok,
  // Controls
  input wire logic osc_en,
  input wire logic pll_en,
  input wire logic sysclk_en,
  input wire logic engine_en,
  input wire logic core_pwr_en,
  input wire logic core_rst_n,
  input wire logic chip_rst_n,
  input wire logic pin_hold,
  input wire logic host_miso_oe,
  // Status
  input wire psc_pkg::psc_state_t power_state,
  input wire logic pd_by_pin
);
  // ----------------------------------------
  // Checks, all in the core clock domain
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  engine_tie_a: assert property (engine_en == sysclk_en) else $error("engine enable off clock");
  // Enable and state are both registered from the next state, so they change on the same edge
  sysclk_src_a: assert property (sysclk_en |-> power_state == ST_ACTIVE || $past(power_state) == ST_ACTIVE)
    else $error("clock on outside active");
  sysclk_on_a: assert property ((power_state == ST_ACTIVE) [*2] |-> sysclk_en) else $error("clock off in active");
  pll_tie_a: assert property (pll_en == osc_en) else $error("pll differs from osc");
  standby_clk_a: assert property ((power_state == ST_STANDBY) [*2] |-> osc_en && !sysclk_en)
    else $error("standby clocks wrong");
  sleep_clk_a: assert property ((power_state == ST_SLEEP) [*2] |-> !osc_en && !sysclk_en)
    else $error("sleep clocks wrong");
  pdown_off_a: assert property ((power_state == ST_PDOWN) [*2] |-> !core_pwr_en && !core_rst_n && !osc_en)
    else $error("powerdown not off");
  pin_pd_a: assert property ($fell(powerdown_reset_pin_n) |-> ##[1:5] power_state == ST_PDOWN)
    else $error("pin did not power down");
  por_pulse_a: assert property ($rose(regulator_ok) |-> ##[1:8] !core_rst_n) else $error("no power-on reset");
  pin_keep_a: assert property ($past(power_state) == ST_ACTIVE && power_state inside {ST_STANDBY, ST_SLEEP}
    |-> ##[0:1] pin_hold) else $error("pins not held");
  miso_float_a: assert property (host_select_line_n [*4] |-> !host_miso_oe) else $error("data out driven");
endmodule : psc_power_chk

bind psc_power_ctrl psc_power_chk psc_power_chk_i (.core_clk(core_clk), .reset_n(reset_n), .host_sck(host_sck),
  .host_select_line_n(host_select_line_n), .host_mosi(host_mosi), .powerdown_reset_pin_n(powerdown_reset_pin_n),
  .regulator_ok(regulator_ok), .osc_en(osc_en), .pll_en(pll_en), .sysclk_en(sysclk_en), .engine_en(engine_en),
  .core_pwr_en(core_pwr_en), .core_rst_n(core_rst_n), .chip_rst_n(chip_rst_n), .pin_hold(pin_hold),
  .host_miso_oe(host_miso_oe), .power_state(power_state), .pd_by_pin(pd_by_pin));

// ### tb/psc_host_mdl.sv
// Behavioural host microcontroller on the serial link
`timescale 1ns/1ps
module psc_host_mdl (
  // Serial pins
  output logic host_sck,
  output logic host_select_line_n,
  output logic host_mosi
);
  // Link idles deselected with its clock standing low
  initial begin
    host_sck = 1'b0;
    host_select_line_n = 1'b1;
    host_mosi = 1'b0;
  end

  // ----------------------------------------
  // One frame, MSB first, 48 ns bit period
  // ----------------------------------------
  task automatic send(input logic [23:0] w, input int gap);
    #(7 + gap);
    host_select_line_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      host_mosi = w[i];
      #24 host_sck = 1'b1;
      #24 host_sck = 1'b0;
    end
    #24 host_select_line_n = 1'b1;
    // Released line shows no stale bit
    host_mosi = ~host_mosi;
  endtask : send
endmodule : psc_host_mdl

// ### tb/tb_psc_power_ctrl.sv
// Self-checking bench for the power-state controller
`timescale 1ns/1ps
module tb_psc_power_ctrl;
  import psc_pkg::*;
  // ----------------------------------------
  // Signals, counters, instances
  // ----------------------------------------
  localparam logic [23:0] RD0 = {PFX_READ, WAKE_ADDR};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic powerdown_reset_pin_n = 1'b1;
  logic regulator_ok = 1'b1;
  logic host_sck, host_select_line_n, host_mosi, osc_en, pll_en, sysclk_en, engine_en;
  logic core_pwr_en, core_rst_n, chip_rst_n, pin_hold, host_miso_oe, pd_by_pin;
  psc_state_t power_state;
  int err_total = 0;
  int num_checks = 0;
  logic [15:0] lfsr = 16'h0017;

  always #4 core_clk = ~core_clk;

  psc_host_mdl psc_host_mdl_i (.host_sck(host_sck), .host_select_line_n(host_select_line_n), .host_mosi(host_mosi));

  // Short counts keep the run brief
  psc_power_ctrl #(.PD_RESET_CYC(50), .SETTLE_CYC(40)) psc_power_ctrl_i (.core_clk(core_clk), .reset_n(reset_n),
    .host_sck(host_sck), .host_select_line_n(host_select_line_n), .host_mosi(host_mosi),
    .powerdown_reset_pin_n(powerdown_reset_pin_n), .regulator_ok(regulator_ok), .osc_en(osc_en), .pll_en(pll_en),
    .sysclk_en(sysclk_en), .engine_en(engine_en), .core_pwr_en(core_pwr_en), .core_rst_n(core_rst_n),
    .chip_rst_n(chip_rst_n), .pin_hold(pin_hold), .host_miso_oe(host_miso_oe), .power_state(power_state),
    .pd_by_pin(pd_by_pin));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step

  // Host command: prefix, code, two ignored bytes
  function automatic logic [23:0] cmd_frame(input logic [5:0] c);
    return {PFX_HOSTCMD, c, 16'h0000};
  endfunction : cmd_frame

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc

  // Bounded wait for a state; a hang ends the run
  task automatic wait_st(input psc_state_t s);
    int n;
    n = 0;
    while (power_state !== s && n < 3000) begin
      wait_cyc(1);
      n++;
    end
    if (n >= 3000) begin
      err_total++;
      results();
    end
  endtask : wait_st

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [23:0] w;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_st(ST_STANDBY);
    check("state", power_state, ST_STANDBY);
    check("osc_en", osc_en, 1'b1);
    check("host_miso_oe", host_miso_oe, 1'b0);
    // Random frames that must be ignored: write, undefined prefix, nonzero address
    for (int k = 0; k < 6; k++) begin
      lfsr = lfsr_step(lfsr);
      w = {lfsr[1:0], 6'h15, lfsr};
      if (w[23:22] == PFX_HOSTCMD) w[23:22] = 2'h3;
      if (w[23:22] == PFX_READ) w[0] = 1'b1;
      psc_host_mdl_i.send(w, lfsr[3:0]);
      wait_cyc(8);
      check("state", power_state, ST_STANDBY);
    end
    // Data out drives only while the host selects
    fork
      psc_host_mdl_i.send(RD0, 0);
      begin
        wait_cyc(40);
        check("host_miso_oe", host_miso_oe, 1'b1);
      end
    join
    wait_st(ST_ACTIVE);
    wait_cyc(2);
    check("sysclk_en", sysclk_en, 1'b1);
    check("engine_en", engine_en, 1'b1);
    psc_host_mdl_i.send(cmd_frame(CMD_STANDBY), 3);
    wait_st(ST_STANDBY);
    wait_cyc(2);
    check("pin_hold", pin_hold, 1'b1);
    check("engine_en", engine_en, 1'b0);
    psc_host_mdl_i.send(RD0, 0);
    wait_st(ST_ACTIVE);
    check("state", power_state, ST_ACTIVE);
    psc_host_mdl_i.send(cmd_frame(CMD_SLEEP), 11);
    wait_st(ST_SLEEP);
    wait_cyc(2);
    check("osc_en", osc_en, 1'b0);
    check("pll_en", pll_en, 1'b0);
    psc_host_mdl_i.send(RD0, 5);
    wait_st(ST_WAKE);
    check("sysclk_en", sysclk_en, 1'b0);
    // Host holds off until the clocks have settled
    wait_st(ST_ACTIVE);
    psc_host_mdl_i.send(cmd_frame(CMD_PWRDOWN), 0);
    wait_st(ST_PDOWN);
    wait_cyc(1);
    check("core_pwr_en", core_pwr_en, 1'b0);
    check("pd_by_pin", pd_by_pin, 1'b0);
    psc_host_mdl_i.send(cmd_frame(CMD_ACTIVE), 2);
    wait_st(ST_PWRUP);
    wait_cyc(1);
    check("core_rst_n", core_rst_n, 1'b0);
    check("chip_rst_n", chip_rst_n, 1'b1);
    wait_st(ST_ACTIVE);
    check("sysclk_en", sysclk_en, 1'b1);
    // Short pin pulse: powerdown without full reset
    @(posedge core_clk) powerdown_reset_pin_n <= 1'b0;
    wait_st(ST_PDOWN);
    wait_cyc(1);
    check("pd_by_pin", pd_by_pin, 1'b1);
    @(posedge core_clk) powerdown_reset_pin_n <= 1'b1;
    psc_host_mdl_i.send(cmd_frame(CMD_ACTIVE), 9);
    wait_st(ST_PWRUP);
    wait_st(ST_ACTIVE);
    check("state", power_state, ST_ACTIVE);
    // Command powerdown, then a long pin low refuses wake-up and resets the chip
    psc_host_mdl_i.send(cmd_frame(CMD_PWRDOWN), 1);
    wait_st(ST_PDOWN);
    @(posedge core_clk) powerdown_reset_pin_n <= 1'b0;
    psc_host_mdl_i.send(cmd_frame(CMD_ACTIVE), 4);
    wait_cyc(8);
    check("state", power_state, ST_PDOWN);
    @(posedge core_clk) powerdown_reset_pin_n <= 1'b1;
    wait_st(ST_PWRUP);
    wait_cyc(1);
    check("chip_rst_n", chip_rst_n, 1'b0);
    wait_st(ST_STANDBY);
    // Regulator drop and rise
    @(posedge core_clk) regulator_ok <= 1'b0;
    wait_cyc(4);
    @(posedge core_clk) regulator_ok <= 1'b1;
    wait_st(ST_PWRUP);
    wait_cyc(1);
    check("core_rst_n", core_rst_n, 1'b0);
    wait_st(ST_STANDBY);
    check("sysclk_en", sysclk_en, 1'b0);
    results();
  end
endmodule : tb_psc_power_ctrl
